// file: verilog/fspc_pkg.sv
// constants and carriers of the flash self-programming controller
//=========================================
package fspc_pkg;
  localparam int PTR_W = 16;
  localparam int DATA_W = 8;
  localparam int WORD_W = 16;
  localparam int WORD_IDX_W = 5;
  localparam int WORD_LSB = 1;
  localparam int PAGE_LSB = WORD_LSB + WORD_IDX_W;
  localparam int PAGE_W = PTR_W - PAGE_LSB;
  localparam int LOCK_W = 6;
  localparam int CMD_W = 5;
  localparam int ADDR_W = 3;
  localparam int ARM_W = 3;
  // register offsets
  localparam logic [ADDR_W-1:0] OFS_CTRL = 3'h0;
  localparam logic [ADDR_W-1:0] OFS_PTR_LO = 3'h1;
  localparam logic [ADDR_W-1:0] OFS_PTR_HI = 3'h2;
  localparam logic [ADDR_W-1:0] OFS_DATA_LO = 3'h3;
  localparam logic [ADDR_W-1:0] OFS_DATA_HI = 3'h4;
  // control register fields
  localparam int BIT_ENABLE = 0;
  localparam int BIT_BUSY = 6;
  localparam int BIT_IRQ_EN = 7;
  // command codes in the low five bits
  localparam logic [CMD_W-1:0] CMD_LOAD = 5'h01;
  localparam logic [CMD_W-1:0] CMD_ERASE = 5'h03;
  localparam logic [CMD_W-1:0] CMD_WRITE = 5'h05;
  localparam logic [CMD_W-1:0] CMD_LOCK = 5'h09;
  localparam logic [CMD_W-1:0] CMD_REENABLE = 5'h11;
  localparam logic [CMD_W-1:0] CMD_IDLE = 5'h00;
  localparam logic [ARM_W-1:0] SPM_WINDOW = 3'h4;
  // timing
  localparam int CLK_PERIOD_NS = 40;
  localparam int PROG_MIN_NS = 3200000;
  localparam int PROG_CYCLES = (PROG_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [PTR_W-1:0] APP_RESET_ADDR = 16'h0000;
  localparam logic [1:0] FUSE_SETTLE = 2'h2;
  localparam logic [LOCK_W-1:0] LOCK_NONE = 6'h3f;

  typedef enum logic [3:0] {
    FSPC_IDLE = 4'b0001,
    FSPC_ARMED = 4'b0010,
    FSPC_PROG = 4'b0100,
    FSPC_DONE = 4'b1000
  } fspc_state_t;

  typedef struct packed {
    logic erase;
    logic write;
    logic lock;
    logic [PAGE_W-1:0] page;
    logic [LOCK_W-1:0] lockBits;
  } fspc_flash_cmd_t;
endpackage

// file: verilog/fspc_op_timer.sv
// programming duration timer
module fspc_op_timer #(
  parameter int CYCLES = 80000
) (
  // clock and reset
  input wire logic clk,
  input wire logic reset,
  // control
  input wire logic start,
  output logic busy,
  output logic done
);
  localparam int CNT_W = $clog2(CYCLES + 1);
  localparam logic [CNT_W-1:0] LAST = CNT_W'(CYCLES - 1);
  localparam logic [CNT_W-1:0] ONE = CNT_W'(1);

  initial begin
    if (CYCLES < 2) $error("fspc_op_timer: CYCLES must be at least 2");
  end

  logic [CNT_W-1:0] count;

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      count <= '0;
      busy <= 1'b0;
      done <= 1'b0;
    end else begin
      done <= 1'b0;
      if (start && !busy) begin
        busy <= 1'b1;
        count <= '0;
      end else if (busy) begin
        if (count == LAST) begin
          busy <= 1'b0;
          done <= 1'b1;
        end else begin
          count <= count + ONE;
        end
      end
    end
  end
endmodule

// file: verilog/fspc_page_buffer.sv
// temporary page buffer held in flip-flops
module fspc_page_buffer #(
  parameter int DEPTH = 32,
  parameter int WIDTH = 16
) (
  // clock and reset
  input wire logic clk,
  input wire logic reset,
  // fill side
  input wire logic wrEn,
  input wire logic [$clog2(DEPTH)-1:0] wrIdx,
  input wire logic [WIDTH-1:0] wrData,
  input wire logic clear,
  // drain side
  input wire logic [$clog2(DEPTH)-1:0] rdIdx,
  output logic [WIDTH-1:0] rdData,
  output logic anyLoaded
);
  initial begin
    if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0) $error("fspc_page_buffer: bad DEPTH");
  end

  logic [WIDTH-1:0] mem [DEPTH];
  logic [DEPTH-1:0] loaded;

  // erased words read as all ones, like erased flash
  for (genvar i = 0; i < DEPTH; i++) begin : g_entry
    always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
        mem[i] <= '1;
        loaded[i] <= 1'b0;
      end else if (clear) begin
        mem[i] <= '1;
        loaded[i] <= 1'b0;
      end else if (wrEn && wrIdx == i) begin
        mem[i] <= wrData;
        loaded[i] <= 1'b1;
      end
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      rdData <= '1;
      anyLoaded <= 1'b0;
    end else begin
      rdData <= mem[rdIdx];
      anyLoaded <= |loaded;
    end
  end
endmodule

// file: verilog/fspc_flash_self_prog.sv
// flash self-programming controller top level
module fspc_flash_self_prog
  import fspc_pkg::*;
#(
  parameter int PROG_TIME_CYCLES = fspc_pkg::PROG_CYCLES,
  parameter logic [fspc_pkg::PAGE_W-1:0] NO_READ_WHILE_WRITE_SECTION_START_PAGE = 10'h380,
  parameter logic [fspc_pkg::PTR_W-1:0] BOOT_RESET_ADDR = 16'h1c00
) (
  // clock and reset
  input wire logic clk,
  input wire logic reset,
  // register port
  input wire logic [fspc_pkg::ADDR_W-1:0] regAddr,
  input wire logic [fspc_pkg::DATA_W-1:0] regWdata,
  input wire logic regWrite,
  input wire logic regRead,
  output logic [fspc_pkg::DATA_W-1:0] regRdata,
  // cpu side
  input wire logic spmExec,
  input wire logic lpmReq,
  output logic cpuHalt,
  output logic spmIrq,
  output logic [fspc_pkg::PTR_W-1:0] resetVector,
  // fuse pin and eeprom status
  input wire logic bootResetSelectFuse,
  input wire logic eepromWriteBusy,
  // flash array side
  output fspc_pkg::fspc_flash_cmd_t flashCmd,
  input wire logic [fspc_pkg::WORD_IDX_W-1:0] flashWordIdx,
  output logic [fspc_pkg::WORD_W-1:0] flashWordData,
  output logic [fspc_pkg::PTR_W-2:0] flashReadWord,
  output logic flashReadHighByte,
  output logic rwwReadBlock,
  output logic lockReadBlock
);
  initial begin
    if (PROG_TIME_CYCLES < 2) $error("fspc_flash_self_prog: PROG_TIME_CYCLES too small");
  end

  //=========================================
  // state
  fspc_state_t state;
  logic [CMD_W-1:0] cmd;
  logic irqEnable;
  logic busySectionFlag;
  logic [DATA_W-1:0] ptrLow;
  logic [DATA_W-1:0] ptrHigh;
  logic [DATA_W-1:0] dataLow;
  logic [DATA_W-1:0] dataHigh;
  logic [ARM_W-1:0] armCount;
  logic opIsWrite;
  logic fuseMeta;
  logic fuseSync;
  logic [1:0] fuseSettle;
  logic vectorTaken;

  //=========================================
  // decode
  logic [PTR_W-1:0] pointer;
  logic ctrlWrite;
  logic ctrlAccept;
  logic spmTaken;
  logic startLoad;
  logic startErase;
  logic startWrite;
  logic startLock;
  logic startReenable;
  logic timerStart;
  logic timerBusy;
  logic timerDone;
  logic bufClear;
  logic bufLoaded;
  logic [PAGE_W-1:0] ptrPage;
  logic enableBit;

  assign pointer = {ptrHigh, ptrLow};
  assign ptrPage = pointer[PTR_W-1:PAGE_LSB];
  assign enableBit = cmd[BIT_ENABLE];
  assign ctrlWrite = regWrite && regAddr == OFS_CTRL;
  // no control write is taken while an eeprom write runs or flash is busy
  assign ctrlAccept = ctrlWrite && !eepromWriteBusy && state != FSPC_PROG;

  // store instruction counts only inside the arming window
  assign spmTaken = spmExec && state == FSPC_ARMED && armCount < SPM_WINDOW
    && !eepromWriteBusy;
  assign startLoad = spmTaken && cmd == CMD_LOAD;
  assign startErase = spmTaken && cmd == CMD_ERASE;
  assign startWrite = spmTaken && cmd == CMD_WRITE;
  assign startLock = spmTaken && cmd == CMD_LOCK;
  assign startReenable = spmTaken && cmd == CMD_REENABLE;
  assign timerStart = startErase || startWrite || startLock;

  // buffer empties after a page write, a reenable write, or an eeprom write
  // landing in the middle of loading
  assign bufClear = (timerDone && opIsWrite)
    || (ctrlAccept && regWdata[CMD_W-1:0] == CMD_REENABLE)
    || (eepromWriteBusy && bufLoaded);

  //=========================================
  // submodules
  fspc_op_timer #(
    .CYCLES(PROG_TIME_CYCLES)
  ) u_timer (
    .clk(clk),
    .reset(reset),
    .start(timerStart),
    .busy(timerBusy),
    .done(timerDone)
  );

  fspc_page_buffer #(
    .DEPTH(1 << WORD_IDX_W),
    .WIDTH(WORD_W)
  ) u_buffer (
    .clk(clk),
    .reset(reset),
    .wrEn(startLoad),
    .wrIdx(pointer[PAGE_LSB-1:WORD_LSB]),
    .wrData({dataHigh, dataLow}),
    .clear(bufClear),
    .rdIdx(flashWordIdx),
    .rdData(flashWordData),
    .anyLoaded(bufLoaded)
  );

  //=========================================
  // pointer and data registers
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      ptrLow <= '0;
      ptrHigh <= '0;
      dataLow <= '0;
      dataHigh <= '0;
    end else if (regWrite) begin
      case (regAddr)
        OFS_PTR_LO: ptrLow <= regWdata;
        OFS_PTR_HI: ptrHigh <= regWdata;
        OFS_DATA_LO: dataLow <= regWdata;
        OFS_DATA_HI: dataHigh <= regWdata;
        default: begin
        end
      endcase
    end
  end

  //=========================================
  // command sequencer
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      state <= FSPC_IDLE;
      cmd <= CMD_IDLE;
      armCount <= '0;
    end else begin
      case (state)
        FSPC_IDLE: begin
          if (ctrlAccept && regWdata[BIT_ENABLE]) begin
            state <= FSPC_ARMED;
            cmd <= regWdata[CMD_W-1:0];
            armCount <= '0;
          end
        end
        FSPC_ARMED: begin
          if (ctrlAccept) begin
            cmd <= regWdata[BIT_ENABLE] ? regWdata[CMD_W-1:0] : CMD_IDLE;
            state <= regWdata[BIT_ENABLE] ? FSPC_ARMED : FSPC_IDLE;
            armCount <= '0;
          end else if (timerStart) begin
            state <= FSPC_PROG;
          end else if (spmTaken) begin
            state <= FSPC_DONE;
          end else if (armCount >= SPM_WINDOW - 3'h1) begin
            // no store came in time: drop the armed bits
            state <= FSPC_IDLE;
            cmd <= CMD_IDLE;
          end else begin
            armCount <= armCount + 3'h1;
          end
        end
        FSPC_PROG: begin
          if (timerDone) begin
            state <= FSPC_IDLE;
            cmd <= CMD_IDLE;
          end
        end
        FSPC_DONE: begin
          // load and reenable finish at once
          state <= FSPC_IDLE;
          cmd <= CMD_IDLE;
        end
        default: begin
          state <= FSPC_IDLE;
          cmd <= CMD_IDLE;
        end
      endcase
    end
  end

  //=========================================
  // interrupt enable
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      irqEnable <= 1'b0;
    end else if (ctrlAccept) begin
      irqEnable <= regWdata[BIT_IRQ_EN];
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      spmIrq <= 1'b0;
    end else begin
      spmIrq <= irqEnable && !enableBit;
    end
  end

  //=========================================
  // latched target and busy section flag
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      opIsWrite <= 1'b0;
    end else if (startErase || startWrite) begin
      opIsWrite <= startWrite;
    end else if (startLock) begin
      opIsWrite <= 1'b0;
    end
  end

  // set on any erase or write, held until the reenable command runs
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      busySectionFlag <= 1'b0;
    end else if (startErase || startWrite) begin
      busySectionFlag <= 1'b1;
    end else if (startReenable && !timerBusy) begin
      busySectionFlag <= 1'b0;
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      rwwReadBlock <= 1'b0;
    end else begin
      rwwReadBlock <= busySectionFlag || startErase || startWrite;
    end
  end

  //=========================================
  // cpu halt for the no-read-while-write section
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      cpuHalt <= 1'b0;
    end else if ((startErase || startWrite) && ptrPage >= NO_READ_WHILE_WRITE_SECTION_START_PAGE) begin
      cpuHalt <= 1'b1;
    end else if (timerDone || !timerBusy) begin
      cpuHalt <= 1'b0;
    end
  end

  //=========================================
  // flash array commands
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      flashCmd <= '{erase: 1'b0, write: 1'b0, lock: 1'b0, page: '0, lockBits: LOCK_NONE};
    end else begin
      flashCmd.erase <= startErase || (flashCmd.erase && !timerDone);
      flashCmd.write <= startWrite || (flashCmd.write && !timerDone);
      flashCmd.lock <= startLock || (flashCmd.lock && !timerDone);
      if (startErase || startWrite) begin
        flashCmd.page <= ptrPage;
      end
      if (startLock) begin
        // a zero bit in the data byte programs that lock bit
        flashCmd.lockBits <= dataLow[LOCK_W-1:0];
      end
    end
  end

  //=========================================
  // program read addressing
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      flashReadWord <= '0;
      flashReadHighByte <= 1'b0;
    end else if (lpmReq) begin
      flashReadWord <= pointer[PTR_W-1:WORD_LSB];
      flashReadHighByte <= pointer[0];
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      lockReadBlock <= 1'b0;
    end else begin
      lockReadBlock <= eepromWriteBusy;
    end
  end

  //=========================================
  // boot fuse sampling, read only to the cpu
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      fuseMeta <= 1'b1;
      fuseSync <= 1'b1;
    end else begin
      fuseMeta <= bootResetSelectFuse;
      fuseSync <= fuseMeta;
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      fuseSettle <= '0;
      vectorTaken <= 1'b0;
      resetVector <= APP_RESET_ADDR;
    end else if (!vectorTaken) begin
      if (fuseSettle == FUSE_SETTLE) begin
        vectorTaken <= 1'b1;
        resetVector <= fuseSync ? APP_RESET_ADDR : BOOT_RESET_ADDR;
      end else begin
        fuseSettle <= fuseSettle + 2'h1;
      end
    end
  end

  //=========================================
  // register read port
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      regRdata <= '0;
    end else if (regRead) begin
      case (regAddr)
        OFS_CTRL: begin
          regRdata <= '0;
          regRdata[CMD_W-1:0] <= cmd;
          regRdata[BIT_BUSY] <= busySectionFlag;
          regRdata[BIT_IRQ_EN] <= irqEnable;
        end
        OFS_PTR_LO: regRdata <= ptrLow;
        OFS_PTR_HI: regRdata <= ptrHigh;
        OFS_DATA_LO: regRdata <= dataLow;
        OFS_DATA_HI: regRdata <= dataHigh;
        default: regRdata <= '0;
      endcase
    end else begin
      regRdata <= '0;
    end
  end
endmodule

// file: test/fspc_flash_self_prog_monitor.sv
// port checker of the flash self-programming controller
module fspc_flash_self_prog_monitor #(
  parameter int PROG_TIME_CYCLES = fspc_pkg::PROG_CYCLES,
  parameter logic [fspc_pkg::PAGE_W-1:0] NO_READ_WHILE_WRITE_SECTION_START_PAGE = 10'h380,
  parameter logic [fspc_pkg::PTR_W-1:0] BOOT_RESET_ADDR = 16'h1c00
) (
  // clock and reset
  input wire logic clk,
  input wire logic reset,
  // register port and cpu
  input wire logic [fspc_pkg::ADDR_W-1:0] regAddr,
  input wire logic [fspc_pkg::DATA_W-1:0] regWdata,
  input wire logic regWrite,
  input wire logic spmExec,
  input wire logic lpmReq,
  input wire logic cpuHalt,
  input wire logic [fspc_pkg::PTR_W-1:0] resetVector,
  input wire logic bootResetSelectFuse,
  input wire logic eepromWriteBusy,
  // flash side
  input wire fspc_pkg::fspc_flash_cmd_t flashCmd,
  input wire logic [fspc_pkg::PTR_W-2:0] flashReadWord,
  input wire logic flashReadHighByte,
  input wire logic rwwReadBlock,
  input wire logic lockReadBlock
);
  import fspc_pkg::*;
  logic opActive;
  logic pgOp;
  logic [PTR_W-1:0] ptr;
  logic [DATA_W-1:0] r0;
  int opLen;
  int sinceRst;
  assign opActive = flashCmd.erase | flashCmd.write | flashCmd.lock;
  assign pgOp = flashCmd.erase | flashCmd.write;
  //========================================
  // shadows of pointer and data byte
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      ptr <= 16'h0000;
      r0 <= 8'h00;
    end else if (regWrite) begin
      if (regAddr == OFS_PTR_LO) ptr[7:0] <= regWdata;
      if (regAddr == OFS_PTR_HI) ptr[15:8] <= regWdata;
      if (regAddr == OFS_DATA_LO) r0 <= regWdata;
    end
  end
  // length of the running operation
  always_ff @(posedge clk or posedge reset) begin
    if (reset) opLen <= 0;
    else if (opActive) opLen <= opLen + 1;
    else opLen <= 0;
  end
  // cycles since reset release, saturating
  always_ff @(posedge clk or posedge reset) begin
    if (reset) sinceRst <= 0;
    else if (sinceRst < 8) sinceRst <= sinceRst + 1;
  end
  //========================================
  // assertions
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);
  AST_RVEC_SEL: assert property (sinceRst == 5 |->
    resetVector == (bootResetSelectFuse ? APP_RESET_ADDR : BOOT_RESET_ADDR))
    else $error("reset vector does not match fuse");
  AST_RVEC_HOLD: assert property (sinceRst > 5 |-> $stable(resetVector))
    else $error("reset vector changed after capture");
  AST_LPM_ADDR: assert property (lpmReq |=>
    {flashReadWord, flashReadHighByte} == $past(ptr))
    else $error("program read address wrong");
  AST_PAGE_LATCH: assert property ($rose(pgOp) |->
    flashCmd.page == $past(ptr[PTR_W-1:PAGE_LSB]))
    else $error("page not taken from pointer");
  AST_PAGE_HOLD: assert property (pgOp && $past(pgOp) |-> $stable(flashCmd.page))
    else $error("page changed during operation");
  AST_LOCKBITS: assert property ($rose(flashCmd.lock) |->
    flashCmd.lockBits == $past(r0[LOCK_W-1:0]))
    else $error("lock pattern wrong");
  AST_HALT: assert property (cpuHalt == (pgOp && flashCmd.page >= NO_READ_WHILE_WRITE_SECTION_START_PAGE))
    else $error("halt does not follow target section");
  AST_BUSY: assert property (pgOp |-> rwwReadBlock)
    else $error("section not blocked during operation");
  AST_BUSY_STICK: assert property (rwwReadBlock && !spmExec && !$past(spmExec) |=> rwwReadBlock)
    else $error("busy flag cleared without store");
  AST_LOCK_RW: assert property (flashCmd.lock |-> !cpuHalt && !rwwReadBlock)
    else $error("lock write blocks or halts");
  // the command bit stays up one cycle past the timer's count
  AST_OP_LEN: assert property ($fell(opActive) |-> opLen == PROG_TIME_CYCLES + 1)
    else $error("operation length wrong");
  AST_EE_LOCKRD: assert property (lockReadBlock == $past(eepromWriteBusy))
    else $error("lock read block does not follow eeprom");
  AST_EE_NOSTART: assert property (eepromWriteBusy |=> !$rose(opActive))
    else $error("operation started during eeprom write");
  COV_HALT: cover property ($rose(cpuHalt));
  COV_LOCK: cover property ($rose(flashCmd.lock));
  COV_LPM: cover property (lpmReq);
  COV_REEN: cover property ($fell(rwwReadBlock));
endmodule

// file: test/fspc_cpu.sv
// model of the cpu core that runs the boot loader
module fspc_cpu
  import fspc_pkg::*;
(
  // clock
  input wire logic clk,
  // register port
  output logic [fspc_pkg::ADDR_W-1:0] regAddr,
  output logic [fspc_pkg::DATA_W-1:0] regWdata,
  output logic regWrite,
  output logic regRead,
  input wire logic [fspc_pkg::DATA_W-1:0] regRdata,
  // instruction pulses
  output logic spmExec,
  output logic lpmReq
);
  timeunit 1ns;
  timeprecision 1ns;
  initial begin
    regAddr = 3'h0;
    regWdata = 8'h00;
    regWrite = 1'b0;
    regRead = 1'b0;
    spmExec = 1'b0;
    lpmReq = 1'b0;
  end
  // released lines show the inverse so stale values are not trusted
  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    @(posedge clk);
    regAddr <= a;
    regWdata <= d;
    regWrite <= 1'b1;
    @(posedge clk);
    regWrite <= 1'b0;
    regAddr <= ~a;
    regWdata <= ~d;
  endtask
  task automatic rd(input logic [2:0] a, output logic [7:0] d);
    @(posedge clk);
    regAddr <= a;
    regRead <= 1'b1;
    @(posedge clk);
    regRead <= 1'b0;
    @(posedge clk);
    d = regRdata;
  endtask
  // arm then store after k cycles, k above 4 is a late store
  task automatic cmd(input logic [7:0] v, input int k);
    wr(OFS_CTRL, v);
    repeat (k - 1) @(posedge clk);
    spmExec <= 1'b1;
    @(posedge clk);
    spmExec <= 1'b0;
  endtask
  task automatic lpm();
    @(posedge clk);
    lpmReq <= 1'b1;
    @(posedge clk);
    lpmReq <= 1'b0;
  endtask
endmodule

// file: test/tb_top.sv
// self-checking bench of the flash self-programming controller
module tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  import fspc_pkg::*;
  localparam int PROG = 20;
  localparam logic [PAGE_W-1:0] NO_READ_WHILE_WRITE_SECTION_PG = 10'h380;
  localparam logic [PTR_W-1:0] BOOT_VEC = 16'h1c00; // arbitrary
  logic clk, reset, bootResetSelectFuse, eepromWriteBusy, spmExec, lpmReq;
  logic cpuHalt, spmIrq, flashReadHighByte, rwwReadBlock, lockReadBlock;
  logic regWrite, regRead;
  logic [2:0] regAddr;
  logic [7:0] regWdata, regRdata, r0v;
  logic [4:0] flashWordIdx;
  logic [15:0] resetVector, flashWordData;
  logic [14:0] flashReadWord;
  fspc_flash_cmd_t flashCmd;
  int err_total, num_checks, cycles, seed, p;
  int bufModel[32];
  int loaded[$];
  int slots[4] = '{3, 10, 17, 31};
  fspc_flash_self_prog #(.PROG_TIME_CYCLES(PROG), .NO_READ_WHILE_WRITE_SECTION_START_PAGE(NO_READ_WHILE_WRITE_SECTION_PG),
    .BOOT_RESET_ADDR(BOOT_VEC)) u_fspc_flash_self_prog (.clk(clk), .reset(reset),
    .regAddr(regAddr), .regWdata(regWdata), .regWrite(regWrite), .regRead(regRead),
    .regRdata(regRdata), .spmExec(spmExec), .lpmReq(lpmReq), .cpuHalt(cpuHalt),
    .spmIrq(spmIrq), .resetVector(resetVector), .bootResetSelectFuse(bootResetSelectFuse),
    .eepromWriteBusy(eepromWriteBusy), .flashCmd(flashCmd), .flashWordIdx(flashWordIdx),
    .flashWordData(flashWordData), .flashReadWord(flashReadWord),
    .flashReadHighByte(flashReadHighByte), .rwwReadBlock(rwwReadBlock),
    .lockReadBlock(lockReadBlock));
  fspc_cpu u_fspc_cpu (.clk(clk), .regAddr(regAddr), .regWdata(regWdata),
    .regWrite(regWrite), .regRead(regRead), .regRdata(regRdata), .spmExec(spmExec),
    .lpmReq(lpmReq));
  always #20 clk = ~clk;
  always @(posedge clk) begin
    cycles++;
    if (cycles == 20000) begin
      err_total++;
      wrap_up();
    end
  end
  //========================================
  // helpers
  task automatic wrap_up();
    $display("checks %0d errors %0d", num_checks, err_total);
    if (err_total == 0 && num_checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      err_total++;
      $display("ERROR at %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic rdc(input logic [2:0] a, input logic [7:0] e);
    logic [7:0] v;
    u_fspc_cpu.rd(a, v);
    chk(v, e);
  endtask
  task automatic bufc(input int i);
    flashWordIdx <= i[4:0];
    repeat (2) @(posedge clk);
    chk(flashWordData, bufModel[i]);
  endtask
  task automatic setptr(input logic [15:0] v);
    u_fspc_cpu.wr(OFS_PTR_LO, v[7:0]);
    u_fspc_cpu.wr(OFS_PTR_HI, v[15:8]);
  endtask
  task automatic clr_model();
    foreach (bufModel[i]) bufModel[i] = 32'hffff;
    loaded.delete();
  endtask
  task automatic load(input int s);
    logic [15:0] d;
    d = $random(seed);
    setptr({10'h000, s[4:0], 1'b0});
    u_fspc_cpu.wr(OFS_DATA_LO, d[7:0]);
    u_fspc_cpu.wr(OFS_DATA_HI, d[15:8]);
    u_fspc_cpu.cmd(8'h01, 1 + $unsigned($random(seed)) % 4);
    bufModel[s] = d;
    loaded.push_back(s);
  endtask
  task automatic wait_idle();
    int n;
    n = 0;
    while ((flashCmd.erase | flashCmd.write | flashCmd.lock) && n < PROG + 10) begin
      @(posedge clk);
      n++;
    end
    chk(n < PROG + 10, 1);
    @(posedge clk);
  endtask
  //========================================
  // main sequence
  initial begin
    clk = 0;
    reset = 1;
    bootResetSelectFuse = 0;
    eepromWriteBusy = 0;
    flashWordIdx = 5'h00;
    seed = 32'hb709;
    clr_model();
    repeat (4) @(posedge clk);
    reset <= 0;
    repeat (6) @(posedge clk);
    chk(resetVector, BOOT_VEC);
    bootResetSelectFuse <= 1;
    repeat (4) @(posedge clk);
    chk(resetVector, BOOT_VEC);
    rdc(OFS_CTRL, 8'h00);
    rdc(3'h7, 8'h00);
    foreach (slots[i]) load(slots[i]);
    foreach (loaded[i]) bufc(loaded[i]);
    bufc(0);
    eepromWriteBusy <= 1;
    repeat (2) @(posedge clk);
    chk(lockReadBlock, 1);
    u_fspc_cpu.cmd(8'h03, 1);
    repeat (2) @(posedge clk);
    chk(flashCmd.erase, 0);
    eepromWriteBusy <= 0;
    clr_model();
    rdc(OFS_CTRL, 8'h00);
    foreach (slots[i]) bufc(slots[i]);
    load(5);
    u_fspc_cpu.cmd(8'h11, 1);
    clr_model();
    bufc(5);
    load(0);
    load(31);
    setptr(16'he940);
    u_fspc_cpu.cmd(8'h85, 2);
    repeat (2) @(posedge clk);
    chk(cpuHalt, 1);
    chk(spmIrq, 0);
    u_fspc_cpu.wr(OFS_PTR_HI, 8'h00);
    chk(flashCmd.page, 10'h3a5);
    rdc(OFS_CTRL, 8'hc5);
    wait_idle();
    clr_model();
    chk(cpuHalt, 0);
    rdc(OFS_CTRL, 8'hc0);
    chk(spmIrq, 1);
    bufc(0);
    bufc(31);
    u_fspc_cpu.cmd(8'h91, 1);
    rdc(OFS_CTRL, 8'h80);
    setptr(16'h04ab);
    u_fspc_cpu.cmd(8'h03, 4);
    repeat (2) @(posedge clk);
    chk(flashCmd.erase, 1);
    chk(flashCmd.page, 10'h012);
    chk(cpuHalt, 0);
    chk(rwwReadBlock, 1);
    wait_idle();
    u_fspc_cpu.cmd(8'h11, 1);
    u_fspc_cpu.cmd(8'h03, 5);
    repeat (2) @(posedge clk);
    chk(flashCmd.erase, 0);
    rdc(OFS_CTRL, 8'h00);
    r0v = {2'b11, 6'($random(seed))};
    setptr(16'h0001);
    u_fspc_cpu.wr(OFS_DATA_LO, r0v);
    u_fspc_cpu.cmd(8'h09, 3);
    repeat (2) @(posedge clk);
    chk(flashCmd.lock, 1);
    chk(flashCmd.lockBits, r0v[5:0]);
    chk({cpuHalt, rwwReadBlock}, 2'b00);
    wait_idle();
    rdc(OFS_CTRL, 8'h00);
    repeat (3) begin
      p = $random(seed);
      setptr(p[15:0]);
      u_fspc_cpu.lpm();
      @(posedge clk);
      chk({flashReadWord, flashReadHighByte}, p[15:0]);
    end
    load(17);
    reset <= 1;
    repeat (4) @(posedge clk);
    reset <= 0;
    clr_model();
    repeat (6) @(posedge clk);
    chk(resetVector, 16'h0000);
    bufc(17);
    wrap_up();
  end
endmodule
bind fspc_flash_self_prog fspc_flash_self_prog_monitor #(.PROG_TIME_CYCLES(PROG_TIME_CYCLES),
  .NO_READ_WHILE_WRITE_SECTION_START_PAGE(NO_READ_WHILE_WRITE_SECTION_START_PAGE), .BOOT_RESET_ADDR(BOOT_RESET_ADDR)) u_mon (.clk(clk),
  .reset(reset), .regAddr(regAddr), .regWdata(regWdata), .regWrite(regWrite),
  .spmExec(spmExec), .lpmReq(lpmReq), .cpuHalt(cpuHalt), .resetVector(resetVector),
  .bootResetSelectFuse(bootResetSelectFuse), .eepromWriteBusy(eepromWriteBusy),
  .flashCmd(flashCmd), .flashReadWord(flashReadWord), .flashReadHighByte(flashReadHighByte),
  .rwwReadBlock(rwwReadBlock), .lockReadBlock(lockReadBlock));
